/* File: rtl/difd_decoder.sv */
`timescale 1ns/1ps
module difd_decoder #(
   parameter int DEB_CYC = difd_pkg::DEBOUNCE_CYC,
   parameter int UNIT_CYC = difd_pkg::DELAY_UNIT_CYC,
   parameter int BLINK = difd_pkg::BLINK_CYC,
   parameter int GSTEP = difd_pkg::GAIN_STEP_CYC
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire difd_pkg::difd_term_t term_in,
   input wire logic signed [15:0] speed_cmd_in,
   input wire logic signed [15:0] regulator_in,
   input wire difd_pkg::difd_pr_mode_t process_regulator_enable_setting_in,
   input wire logic [15:0] timer_on_delay_in,
   input wire logic [15:0] timer_off_delay_in,
   input wire logic [15:0] gain1_in,
   input wire logic [15:0] gain2_in,
   input wire logic [15:0] gain_transition_time_in,
   input wire logic [15:0] torque_limit_setting_in,
   input wire logic keypad_torque_mode_in,
   input wire logic motor_stopped_in,
   input wire logic signed [15:0] flux_analog_in,
   input wire logic signed [15:0] flux_default_in,
   output logic fwd_run_out,
   output logic rev_run_out,
   output logic gate_enable_out,
   output logic ext_trip_fault_out,
   output logic stop_lamp_out,
   output logic signed [15:0] speed_cmd_out,
   output logic regulator_enable_out,
   output logic signed [15:0] regulator_out,
   output logic timer_out,
   output logic [2:0] ramp_set_out,
   output logic gain_set_out,
   output logic [15:0] speed_gain_out,
   output logic integral_enable_out,
   output logic signed [15:0] flux_ref_out,
   output logic magnetize_out,
   output logic torque_mode_out,
   output logic [15:0] torque_limit_out
);
   // -----------------------------------------------------------------
   // input conditioning
   // -----------------------------------------------------------------
   logic [difd_pkg::TERM_W-1:0] sync1, sync2, clean;
   logic [15:0] deb_cnt [difd_pkg::TERM_W];
   difd_pkg::difd_term_t t;
   assign t = difd_pkg::difd_term_t'(clean);

   // two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1 <= difd_pkg::TERM_RESET;
         sync2 <= difd_pkg::TERM_RESET;
      end else begin
         sync1 <= term_in;
         sync2 <= sync1;
      end
   end

   // per-terminal debounce: value taken after DEB_CYC stable cycles
   for (genvar i = 0; i < difd_pkg::TERM_W; i++) begin : g_deb
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            deb_cnt[i] <= 16'h0000;
            clean[i] <= difd_pkg::TERM_RESET[i];
         end else if (sync2[i] == clean[i]) begin
            deb_cnt[i] <= 16'h0000;
         end else if (deb_cnt[i] >= 16'(DEB_CYC - 1)) begin
            deb_cnt[i] <= 16'h0000;
            clean[i] <= sync2[i];
         end else begin
            deb_cnt[i] <= deb_cnt[i] + 16'h0001;
         end
      end
   end

   // -----------------------------------------------------------------
   // three-wire run latch and external trip
   // -----------------------------------------------------------------
   logic fwd_d, rev_d, trip, run_any;
   logic [31:0] blink_cnt;
   logic blink;
   wire fwd_rel = fwd_d && !t.fwd_run;
   wire rev_rel = rev_d && !t.rev_run;
   wire trip_now = !t.ext_trip_ok;
   wire trip_hit = trip_now || trip;
   // latch on falling edge of a pulse; three-wire off clears all
   wire next_fwd = t.three_wire && !trip_hit &&
                   (fwd_rel || (fwd_run_out && !rev_rel));
   wire next_rev = t.three_wire && !trip_hit &&
                   (rev_rel || (rev_run_out && !fwd_rel));
   assign run_any = fwd_run_out || rev_run_out;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fwd_d <= 1'b0;
         rev_d <= 1'b0;
         fwd_run_out <= 1'b0;
         rev_run_out <= 1'b0;
      end else begin
         fwd_d <= t.fwd_run;
         rev_d <= t.rev_run;
         fwd_run_out <= next_fwd;
         rev_run_out <= next_rev;
      end
   end

   // trip latches; reset terminal clears it only once the contact closes
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trip <= 1'b0;
         blink_cnt <= 32'h00000000;
         blink <= 1'b0;
      end else begin
         trip <= trip_now || (trip && !t.fault_reset);
         if (blink_cnt >= 32'(BLINK - 1)) begin
            blink_cnt <= 32'h00000000;
            blink <= !blink;
         end else begin
            blink_cnt <= blink_cnt + 32'h00000001;
         end
      end
   end

   // gating drops on the same edge the trip is seen
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gate_enable_out <= 1'b0;
         ext_trip_fault_out <= 1'b0;
         stop_lamp_out <= 1'b0;
      end else begin
         gate_enable_out <= !trip_hit;
         ext_trip_fault_out <= trip_hit;
         stop_lamp_out <= trip_hit ? blink : 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // direction blocking and process regulator
   // -----------------------------------------------------------------
   wire cmd_pos = speed_cmd_in > 16'sh0000;
   wire cmd_neg = speed_cmd_in < 16'sh0000;
   wire cmd_zero = (t.forward_block && cmd_pos) ||
                   (t.reverse_block && cmd_neg);
   wire pr_mode_ok =
      (process_regulator_enable_setting_in == difd_pkg::DIFD_PR_ENABLE) ||
      ((process_regulator_enable_setting_in == difd_pkg::DIFD_PR_TERMINAL)
       && !t.process_regulator_inhibit);
   wire next_pr_en = pr_mode_ok && run_any;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         speed_cmd_out <= difd_pkg::SPEED_ZERO;
         regulator_enable_out <= 1'b0;
         regulator_out <= difd_pkg::REG_ZERO;
      end else begin
         speed_cmd_out <= cmd_zero ? difd_pkg::SPEED_ZERO : speed_cmd_in;
         regulator_enable_out <= next_pr_en;
         regulator_out <= next_pr_en ? regulator_in : difd_pkg::REG_ZERO;
      end
   end

   // -----------------------------------------------------------------
   // on/off delay timer
   // -----------------------------------------------------------------
   function automatic logic [15:0] clamp_delay(input logic [15:0] d);
      clamp_delay = (d < difd_pkg::DELAY_MIN) ? difd_pkg::DELAY_MIN :
                    (d > difd_pkg::DELAY_MAX) ? difd_pkg::DELAY_MAX : d;
   endfunction : clamp_delay

   logic [31:0] unit_cnt;
   logic [15:0] units;
   wire [15:0] tgt = timer_out ? clamp_delay(timer_off_delay_in) :
                     clamp_delay(timer_on_delay_in);
   wire differs = t.timer_in != timer_out;
   wire unit_tick = unit_cnt >= 32'(UNIT_CYC - 1);
   wire elapsed = unit_tick && (units + 16'h0001 >= tgt);

   // any return to the output level restarts the delay
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unit_cnt <= 32'h00000000;
         units <= 16'h0000;
         timer_out <= 1'b0;
      end else if (!differs || elapsed) begin
         unit_cnt <= 32'h00000000;
         units <= 16'h0000;
         timer_out <= differs ? t.timer_in : timer_out;
      end else if (unit_tick) begin
         unit_cnt <= 32'h00000000;
         units <= units + 16'h0001;
      end else begin
         unit_cnt <= unit_cnt + 32'h00000001;
      end
   end

   // -----------------------------------------------------------------
   // ramp set, gain set, mode and limits
   // -----------------------------------------------------------------
   wire [1:0] ramp_idx = {t.ramp_hi, t.ramp_lo};
   wire [2:0] next_ramp = t.ramp_bypass ? difd_pkg::RAMP_SHORTEST :
                          {1'b0, ramp_idx};
   wire [15:0] gain_tgt = t.speed_gain_set_select ? gain2_in : gain1_in;
   // 32 bits: the full-speed step count does not fit in 16
   logic [31:0] gstep_cnt;
   wire gain_tick = gstep_cnt >= 32'(GSTEP - 1);
   // zero transition time steps straight to the new gain
   wire [15:0] next_gain =
      (gain_transition_time_in == 16'h0000) ? gain_tgt :
      !gain_tick ? speed_gain_out :
      (speed_gain_out < gain_tgt) ? speed_gain_out + difd_pkg::GAIN_STEP :
      (speed_gain_out > gain_tgt) ? speed_gain_out - difd_pkg::GAIN_STEP :
      speed_gain_out;
   wire mode_req = t.torque_mode_select | keypad_torque_mode_in;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gstep_cnt <= 32'h00000000;
         speed_gain_out <= 16'h0000;
      end else begin
         gstep_cnt <= gain_tick ? 32'h00000000 : gstep_cnt + 32'h00000001;
         speed_gain_out <= next_gain;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ramp_set_out <= 3'h0;
         gain_set_out <= 1'b0;
         integral_enable_out <= 1'b0;
         flux_ref_out <= 16'sh0000;
         magnetize_out <= 1'b0;
         torque_mode_out <= 1'b0;
         torque_limit_out <= 16'h0000;
      end else begin
         ramp_set_out <= next_ramp;
         gain_set_out <= t.speed_gain_set_select;
         integral_enable_out <= t.speed_integral_select;
         flux_ref_out <= t.flux_ref_select ? flux_analog_in :
                         flux_default_in;
         magnetize_out <= t.premagnetize_request && !run_any;
         if (motor_stopped_in && !run_any) begin
            torque_mode_out <= mode_req;
         end
         torque_limit_out <= t.max_torque ? difd_pkg::TORQUE_MAX :
                             torque_limit_setting_in;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_trip_gate_off: assert property (trip_now |=> !gate_enable_out)
      else $error("gating not dropped on trip");
   a_trip_fault_flag: assert property (trip_now |=> ext_trip_fault_out)
      else $error("trip fault not posted");
   a_three_wire_off: assert property (!t.three_wire |=> !run_any)
      else $error("run latched with three-wire off");
   a_run_latch_fwd: assert property (t.three_wire && fwd_rel && !trip_hit
      |=> fwd_run_out)
      else $error("forward pulse not latched");
   a_fwd_block_zero: assert property (t.forward_block && cmd_pos
      |=> speed_cmd_out == 16'sh0000)
      else $error("forward command not blocked");
   a_rev_block_zero: assert property (t.reverse_block && cmd_neg
      |=> speed_cmd_out == 16'sh0000)
      else $error("reverse command not blocked");
   a_reg_no_run: assert property (!run_any |=> !regulator_enable_out)
      else $error("regulator enabled without run");
   a_reg_zero_out: assert property (!regulator_enable_out
      |-> regulator_out == 16'sh0000)
      else $error("disabled regulator output not zero");
   a_reg_terminal: assert property (run_any && t.process_regulator_inhibit
      && process_regulator_enable_setting_in == difd_pkg::DIFD_PR_TERMINAL
      |=> !regulator_enable_out)
      else $error("inhibit ignored in terminal mode");
   a_ramp_bypass: assert property (t.ramp_bypass
      |=> ramp_set_out == difd_pkg::RAMP_SHORTEST)
      else $error("ramp bypass not applied");
   a_mode_hold_run: assert property (run_any
      |=> $stable(torque_mode_out))
      else $error("mode changed while running");
   a_max_torque: assert property (t.max_torque
      |=> torque_limit_out == difd_pkg::TORQUE_MAX)
      else $error("max torque not applied");
   a_premag_run: assert property (run_any |=> !magnetize_out)
      else $error("magnetizing while running");
   // selections follow their terminals one cycle after conditioning
   a_ramp_select: assert property (!t.ramp_bypass
      |=> ramp_set_out == {1'b0, $past(ramp_idx)})
      else $error("ramp set does not follow select inputs");
   a_gain_select: assert property (t.speed_gain_set_select
      |=> gain_set_out)
      else $error("gain set 2 not selected");
   a_integral_sel: assert property (!t.speed_integral_select
      |=> !integral_enable_out)
      else $error("integral action left on in P mode");
   a_flux_select: assert property (t.flux_ref_select
      |=> flux_ref_out == $past(flux_analog_in))
      else $error("flux reference not taken from analog input");
   a_timer_on_hold: assert property (!t.timer_in && !timer_out
      |=> !timer_out)
      else $error("timer output rose without input");
   // between step ticks the ramped gain must not move
   a_gain_no_step: assert property (gain_transition_time_in != 16'h0000
      && !gain_tick |=> $stable(speed_gain_out))
      else $error("gain stepped between ramp ticks");

   c_trip: cover property (trip_now ##1 !gate_enable_out);
   c_fwd_latch: cover property (fwd_rel ##1 fwd_run_out);
   c_rev_latch: cover property (rev_rel ##1 rev_run_out);
   c_timer_on: cover property ($rose(timer_out));
   c_mode_change: cover property ($changed(torque_mode_out));
endmodule : difd_decoder

/* File: rtl/difd_pkg.sv */
package difd_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int DEBOUNCE_NS = 1000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam int DELAY_UNIT_MS = 100;
   localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * CLK_MHZ * 1000;
   localparam logic [15:0] DELAY_MIN = 16'h0001;
   localparam logic [15:0] DELAY_MAX = 16'h8ca0;
   localparam int BLINK_CYC = 62500000;
   localparam int GAIN_STEP_CYC = 250000;

   // -----------------------------------------------------------------
   // settings and selections
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      DIFD_PR_DISABLE,
      DIFD_PR_ENABLE,
      DIFD_PR_TERMINAL
   } difd_pr_mode_t;

   localparam logic [1:0] RAMP_SET_1 = 2'h0;
   localparam logic [1:0] RAMP_SET_4 = 2'h3;
   localparam logic [2:0] RAMP_SHORTEST = 3'h4;
   localparam logic [15:0] SPEED_ZERO = 16'h0000;
   localparam logic [15:0] REG_ZERO = 16'h0000;
   localparam logic [15:0] TORQUE_MAX = 16'h7fff;
   localparam logic [15:0] GAIN_STEP = 16'h0001;

   // terminal bundle after conditioning
   typedef struct packed {
      logic fwd_run;
      logic rev_run;
      logic three_wire;
      logic ext_trip_ok;
      logic forward_block;
      logic reverse_block;
      logic process_regulator_inhibit;
      logic timer_in;
      logic ramp_lo;
      logic ramp_hi;
      logic ramp_bypass;
      logic speed_gain_set_select;
      logic speed_integral_select;
      logic flux_ref_select;
      logic premagnetize_request;
      logic torque_mode_select;
      logic max_torque;
      logic fault_reset;
   } difd_term_t;

   localparam int TERM_W = $bits(difd_term_t);
   // trip contact idles closed, every other terminal idles open
   localparam difd_term_t TERM_RESET = 18'h04000;
endpackage : difd_pkg

/* File: dv/difd_contacts.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// field contacts and push buttons
// -----------------------------------------------------------------
module difd_contacts (
   input wire difd_pkg::difd_term_t want_in,
   input wire difd_pkg::difd_term_t bounce_in,
   output difd_pkg::difd_term_t term_out
);
   // a set bounce bit flips its contact; the bench holds it one cycle
   assign term_out = want_in ^ bounce_in;
endmodule : difd_contacts

/* File: dv/test_drive_input_function_decoder.sv */
`timescale 1ns/1ps
module test_drive_input_function_decoder;
   // -----------------------------------------------------------------
   // stimulus and outputs
   // -----------------------------------------------------------------
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   difd_pkg::difd_term_t t = '0;
   difd_pkg::difd_term_t bn = '0;
   difd_pkg::difd_term_t term;
   difd_pkg::difd_pr_mode_t mode = difd_pkg::DIFD_PR_DISABLE;
   logic signed [15:0] spd = '0, reg_in = '0, fa = '0, fd = '0;
   logic [15:0] g1 = 16'h000a, g2 = 16'h0014, gt = '0, tl = 16'h1234;
   logic [15:0] don = 16'h0003, doff = 16'h0003;
   logic kp = 1'b0, stopped = 1'b1, run = 1'b0, b;
   logic fwd, rev, gate, flt, lamp, regen, tmr, gsel, integ, mag, tmode;
   logic signed [15:0] spd_o, reg_o, flux_o;
   logic [15:0] gain_o, tlim;
   logic [2:0] ramp;
   logic signed [15:0] cs [4] = '{16'h0001, 16'hffff, 16'h0000, 16'h8000};
   int err_count = 0;
   int checked = 0;

   initial forever #2 mclk_in = ~mclk_in;

   difd_contacts i_contacts (.want_in(t), .bounce_in(bn), .term_out(term));

   // short counts keep delays and blinking inside a brief run
   difd_decoder #(.DEB_CYC(2), .UNIT_CYC(4), .BLINK(4), .GSTEP(2)) i_dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .term_in(term),
      .speed_cmd_in(spd), .regulator_in(reg_in),
      .process_regulator_enable_setting_in(mode),
      .timer_on_delay_in(don), .timer_off_delay_in(doff),
      .gain1_in(g1), .gain2_in(g2), .gain_transition_time_in(gt),
      .torque_limit_setting_in(tl), .keypad_torque_mode_in(kp),
      .motor_stopped_in(stopped), .flux_analog_in(fa),
      .flux_default_in(fd), .fwd_run_out(fwd), .rev_run_out(rev),
      .gate_enable_out(gate), .ext_trip_fault_out(flt),
      .stop_lamp_out(lamp), .speed_cmd_out(spd_o),
      .regulator_enable_out(regen), .regulator_out(reg_o),
      .timer_out(tmr), .ramp_set_out(ramp), .gain_set_out(gsel),
      .speed_gain_out(gain_o), .integral_enable_out(integ),
      .flux_ref_out(flux_o), .magnetize_out(mag),
      .torque_mode_out(tmode), .torque_limit_out(tlim));

   // -----------------------------------------------------------------
   // compare tasks and expectations
   // -----------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : cyc

   // 8 cycles covers sync, debounce and the output register
   task automatic press(input logic rv);
      if (rv) t.rev_run = 1'b1;
      else t.fwd_run = 1'b1;
      cyc(8);
      t.fwd_run = 1'b0;
      t.rev_run = 1'b0;
      cyc(8);
   endtask : press

   function automatic logic [15:0] exp_spd(input logic [15:0] s,
                                           input logic fb, input logic rb);
      if ((fb && !s[15] && s != 0) || (rb && s[15])) return 16'h0000;
      return s;
   endfunction : exp_spd

   function automatic logic exp_pr(input difd_pkg::difd_pr_mode_t m,
                                   input logic inh, input logic r);
      return r && (m == difd_pkg::DIFD_PR_ENABLE ||
                   (m == difd_pkg::DIFD_PR_TERMINAL && !inh));
   endfunction : exp_pr

   task automatic finish_test();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      void'($urandom(49376));
      t.ext_trip_ok = 1'b1;
      cyc(20);
      rst_n_in = 1'b1;
      cyc(8);
      chk_bit(gate, 1'b1);
      for (int i = 0; i < 32; i++) begin
         spd = (i < 8) ? cs[i >> 1] : 16'($urandom);
         {t.forward_block, t.reverse_block} = 2'(i);
         cyc(8);
         chk_word(spd_o, exp_spd(spd, i[1], i[0]));
      end
      for (int i = 0; i < 8; i++) begin
         {t.ramp_bypass, t.ramp_hi, t.ramp_lo} = 3'(i);
         cyc(8);
         chk_word({13'h0, ramp}, i[2] ? 16'h4 : 16'(i[1:0]));
      end
      press(1'b0);
      chk_bit(fwd, 1'b0);
      t.three_wire = 1'b1;
      t.premagnetize_request = 1'b1;
      cyc(8);
      press(1'b0);
      run = 1'b1;
      chk_bit(fwd, 1'b1);
      chk_bit(mag, 1'b0);
      // an opposite pulse moves the latch to reverse
      press(1'b1);
      chk_bit(rev, 1'b1);
      chk_bit(fwd, 1'b0);
      stopped = 1'b0;
      t.torque_mode_select = 1'b1;
      cyc(8);
      chk_bit(tmode, 1'b0);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 6; i++) begin
            mode = difd_pkg::difd_pr_mode_t'(i >> 1);
            t.process_regulator_inhibit = i[0];
            reg_in = 16'($urandom) | 16'h0001;
            cyc(8);
            b = exp_pr(mode, i[0], run);
            chk_bit(regen, b);
            chk_word(reg_o, b ? reg_in : 16'h0000);
         end
         // dropping three-wire releases the latched run
         t.three_wire = 1'b0;
         run = 1'b0;
         cyc(8);
      end
      chk_bit(fwd, 1'b0);
      chk_bit(rev, 1'b0);
      chk_bit(mag, 1'b1);
      chk_bit(tmode, 1'b0);
      stopped = 1'b1;
      cyc(8);
      chk_bit(tmode, 1'b1);
      t.torque_mode_select = 1'b0;
      kp = 1'b1;
      cyc(8);
      chk_bit(tmode, 1'b1);
      kp = 1'b0;
      cyc(8);
      chk_bit(tmode, 1'b0);
      for (int i = 0; i < 4; i++) begin
         t.speed_gain_set_select = i[0];
         t.flux_ref_select = i[1];
         t.max_torque = i[0] ^ i[1];
         t.speed_integral_select = i[0];
         fa = 16'($urandom);
         fd = 16'($urandom);
         tl = 16'($urandom);
         cyc(8);
         chk_bit(integ, i[0]);
         chk_bit(gsel, i[0]);
         chk_word(gain_o, i[0] ? g2 : g1);
         chk_word(flux_o, i[1] ? fa : fd);
         chk_word(tlim, (i[0] ^ i[1]) ? 16'h7fff : tl);
      end
      gt = 16'h0001;
      t.speed_gain_set_select = 1'b0;
      cyc(8);
      chk_bit(gain_o > g1, 1'b1);
      cyc(40);
      chk_word(gain_o, g1);
      bn.max_torque = 1'b1;
      cyc(1);
      bn = '0;
      cyc(8);
      chk_word(tlim, tl);
      // shorter off delay; checks at 8 and 24 cycles cannot tell the two delays apart
      don = 16'h0003;
      doff = 16'h0002;
      t.timer_in = 1'b1;
      cyc(8);
      chk_bit(tmr, 1'b0);
      cyc(16);
      chk_bit(tmr, 1'b1);
      t.timer_in = 1'b0;
      cyc(8);
      chk_bit(tmr, 1'b1);
      cyc(16);
      chk_bit(tmr, 1'b0);
      t.ext_trip_ok = 1'b0;
      t.three_wire = 1'b1;
      cyc(8);
      chk_bit(gate, 1'b0);
      chk_bit(flt, 1'b1);
      b = lamp;
      cyc(4);
      chk_bit(lamp ^ b, 1'b1);
      press(1'b0);
      chk_bit(fwd, 1'b0);
      t.ext_trip_ok = 1'b1;
      cyc(8);
      chk_bit(flt, 1'b1);
      t.fault_reset = 1'b1;
      cyc(8);
      t.fault_reset = 1'b0;
      cyc(8);
      chk_bit(flt, 1'b0);
      chk_bit(gate, 1'b1);
      finish_test();
   end

   // run needs under 2000 cycles; 5000 means a hang
   initial begin
      #(4 * 5000);
      err_count++;
      finish_test();
   end
endmodule : test_drive_input_function_decoder
